// [ubs_pkg.sv]
// constants and types for the usb bus status and attribute block
// assumes a 40 MHz system clock and a full-speed bus (12 Mb/s)
// Function
// R1 - code 000 in ack, 001 in nak
// R2 - code 010 out data0, 110 out data1
// R3 - code 011 setup ack, 111 iso end
// R4 - ep2 [16:14], ep1 [13:11], ep0 [10:8]
// R5 - bit 7 overrun when out exceeds payload
// R6 - overrun when setup data exceeds 8 bytes
// R7 - bit 10 selects byte or word buffer access
// R8 - bit 9 low powers transceiver down
// R9 - bit 8 enables d+ pull-up
// R10 - bit 7 enables the controller
// R11 - bit 5 drives k state for wake-up
// R12 - bit 4 enables transceiver function
// R13 - bit 3 timeout after 18 bit times
// R14 - bit 2 resume from suspend seen
// R15 - bit 1 suspend after 3 ms idle
// R16 - bit 0 bus reset after 2.5 us se0
// R17 - attribute register 0x010, reset 0x40
// R18 - suspend or resume raises bus event flag
// R19 - transaction raises transaction event flag
// R20 - writes to status bits are ignored
`default_nettype none
package ubs_pkg;
    // register byte offsets
    localparam logic [7:0]  OFS_EP_STATUS = 8'h0C;
    localparam logic [7:0]  OFS_ATTR      = 8'h10;
    localparam logic [31:0] ATTR_RESET    = 32'h0000_0040;
    // endpoint status field positions
    localparam int EP0_LSB    = 8;
    localparam int EP1_LSB    = 11;
    localparam int EP2_LSB    = 14;
    localparam int OVERRUN_BIT = 7;
    // attribute field positions
    localparam int BIT_BUFW   = 10;
    localparam int BIT_PWR    = 9;
    localparam int BIT_PULLUP = 8;
    localparam int BIT_CTRLEN = 7;
    localparam int BIT_RSVD6  = 6;
    localparam int BIT_WAKE   = 5;
    localparam int BIT_XCVR   = 4;
    // bus codes
    localparam logic [2:0] CODE_IN_ACK  = 3'h0;
    localparam logic [2:0] CODE_IN_NAK  = 3'h1;
    localparam logic [2:0] CODE_OUT_D0  = 3'h2;
    localparam logic [2:0] CODE_OUT_D1  = 3'h6;
    localparam logic [2:0] CODE_SETUP   = 3'h3;
    localparam logic [2:0] CODE_ISO_END = 3'h7;
    localparam logic [9:0] SETUP_MAX_BYTES = 10'h008;
    // timing, in ns, ps and ms, and derived cycle counts
    localparam int CLK_NS      = 25;
    localparam int BIT_TIME_PS = 83333;   // 1/12 MHz
    localparam int TIMEOUT_BITS = 18;
    localparam int TIMEOUT_CYC =
        (TIMEOUT_BITS * BIT_TIME_PS + CLK_NS * 1000 - 1) / (CLK_NS * 1000);
    localparam int SE0_NS      = 2500;
    localparam int SE0_CYC     = (SE0_NS + CLK_NS - 1) / CLK_NS;
    localparam int IDLE_MS     = 3;
    localparam int IDLE_CYC    = IDLE_MS * 1000000 / CLK_NS;
    // link condition states, one-hot
    typedef enum logic [2:0] {
        LS_ACTIVE  = 3'b001,
        LS_SUSPEND = 3'b010,
        LS_RESET   = 3'b100
    } ubs_link_e;
    // one transaction report from the serial engine
    typedef struct packed {
        logic       valid;   // one-cycle pulse
        logic [1:0] ep;      // endpoint 0..2
        logic [2:0] code;    // bus code
        logic [9:0] bytes;   // received byte count
    } ubs_txn_s;
endpackage : ubs_pkg
`default_nettype wire

// [ubs_core.sv]
// bus status and attribute logic of a full-speed usb device
// assumes an avalon-mm master on clk_sys and a serial engine that
// reports each finished transaction as a one-cycle pulse
`default_nettype none
module ubs_core
    import ubs_pkg::*;
#(
    parameter int IDLE_CYCLES = IDLE_CYC    // shorten for simulation
) (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // avalon-mm slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // transaction reports from the serial engine
    input  wire ubs_txn_s    txn,
    input  wire logic [29:0] max_payload_setting,
    input  wire logic        resp_wait,
    // bus line pins
    input  wire logic        dplus_line_i,
    input  wire logic        dminus_line_i,
    output logic             dplus_line_o,
    output logic             dplus_line_oe,
    output logic             dminus_line_o,
    output logic             dminus_line_oe,
    // control outputs
    output logic             cpu_buffer_width_sel,
    output logic             xcvr_power_on_n,
    output logic             dplus_pullup_on,
    output logic             ctrl_enable,
    output logic             xcvr_function_on,
    output logic             remote_wake_drive,
    // event pulses toward the interrupt logic
    output logic             bus_event_flag,
    output logic             transaction_event_flag
);

    // width of the long idle counter
    // sized for one past the suspend limit so it can saturate
    localparam int CW = $clog2(IDLE_CYCLES + 2);

    // field extract, used for every endpoint slot
    function automatic logic [9:0] ep_payload(
        input logic [29:0] all,
        input logic [1:0]  ep
    );
        logic [9:0] r;
        r = 10'h000;
        case (ep)
            2'd0:    r = all[9:0];
            2'd1:    r = all[19:10];
            2'd2:    r = all[29:20];
            default: r = 10'h000;
        endcase
        return r;
    endfunction : ep_payload

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] dp_sync_q;   // [0] feeds only [1]
    logic [1:0] dm_sync_q;   // [0] feeds only [1]

    // the pins are asynchronous to clk_sys
    // two stages for both data lines
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            dp_sync_q <= 2'b00;
            dm_sync_q <= 2'b00;
        end else begin
            dp_sync_q <= {dp_sync_q[0], dplus_line_i};
            dm_sync_q <= {dm_sync_q[0], dminus_line_i};
        end
    end

    // line conditions from the settled samples
    wire line_se0 = ~dp_sync_q[1] & ~dm_sync_q[1];
    wire line_j   = dp_sync_q[1] & ~dm_sync_q[1];
    wire [1:0] line_cond = {line_se0, line_j};

    // ------------------------------------------------------------
    // attribute register, writable part
    // ------------------------------------------------------------
    logic [10:4] ctrl_q;       // bits 10..4, bit 6 reserved
    logic [2:0]  ep_code_q [3];
    logic        overrun_q;

    // bus decode
    wire hit_attr = (avs_address == OFS_ATTR);
    wire hit_eps  = (avs_address == OFS_EP_STATUS);
    logic ack_q;               // one-cycle answer strobe
    wire  req     = avs_read | avs_write;
    // a write lands only in the answering cycle
    wire  wr_take = avs_write & ack_q;

    // control writes, byte lanes 0 and 1 only
    // lanes 2 and 3 hold only reserved bits
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= ATTR_RESET[10:4];                        // R17
        end else if (wr_take && hit_attr) begin
            // status bits 3..0 have no storage here        // R20
            if (avs_byteenable[0]) begin
                ctrl_q[BIT_CTRLEN] <= avs_writedata[BIT_CTRLEN];
                ctrl_q[BIT_WAKE]   <= avs_writedata[BIT_WAKE];
                ctrl_q[BIT_XCVR]   <= avs_writedata[BIT_XCVR];
            end
            if (avs_byteenable[1]) begin
                ctrl_q[BIT_BUFW]   <= avs_writedata[BIT_BUFW];
                ctrl_q[BIT_PWR]    <= avs_writedata[BIT_PWR];
                ctrl_q[BIT_PULLUP] <= avs_writedata[BIT_PULLUP];
            end
        end
    end

    // control outputs straight from the register
    assign cpu_buffer_width_sel = ctrl_q[BIT_BUFW];   // R7
    assign xcvr_power_on_n      = ctrl_q[BIT_PWR];    // R8
    assign dplus_pullup_on      = ctrl_q[BIT_PULLUP]; // R9
    assign ctrl_enable          = ctrl_q[BIT_CTRLEN]; // R10
    assign remote_wake_drive    = ctrl_q[BIT_WAKE];   // R11
    assign xcvr_function_on     = ctrl_q[BIT_XCVR];   // R12

    // k state for remote wake-up: d+ low, d- high
    assign dplus_line_o   = 1'b0;                     // R11
    assign dminus_line_o  = 1'b1;                     // R11
    assign dplus_line_oe  = remote_wake_drive;        // R11
    assign dminus_line_oe = remote_wake_drive;        // R11

    // detection runs only with controller and transceiver on
    // a powered-down phy would report noise as events
    wire live = ctrl_enable & xcvr_function_on & xcvr_power_on_n;

    // ------------------------------------------------------------
    // endpoint status and overrun
    // ------------------------------------------------------------
    // payload limit of the reporting endpoint
    wire [9:0] mps      = ep_payload(max_payload_setting, txn.ep);
    wire       is_out   = (txn.code == CODE_OUT_D0) |
                          (txn.code == CODE_OUT_D1);
    wire       is_setup = (txn.code == CODE_SETUP);
    // too much data for the endpoint or for a setup stage
    wire       ovr_now  = (is_out & (txn.bytes > mps)) |         // R5
                          (is_setup & (txn.bytes > SETUP_MAX_BYTES)); // R6
    // reports while disabled or for ep3 are dropped
    wire       txn_ok   = txn.valid & ctrl_enable & (txn.ep != 2'd3);

    // last code per endpoint; cpu writes never reach here
    // overrun follows the latest accepted report of any endpoint
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ep_code_q[0] <= CODE_IN_ACK;
            ep_code_q[1] <= CODE_IN_ACK;
            ep_code_q[2] <= CODE_IN_ACK;
            overrun_q    <= 1'b0;
        end else if (txn_ok) begin
            ep_code_q[txn.ep] <= txn.code;                 // R1 R2 R3
            overrun_q         <= ovr_now;                  // R5 R6
        end
    end

    // one pulse per accepted transaction
    logic txn_evt_q;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            txn_evt_q <= 1'b0;
        end else begin
            txn_evt_q <= txn_ok;                           // R19
        end
    end
    assign transaction_event_flag = txn_evt_q;

    // ------------------------------------------------------------
    // line condition timer and link state
    // ------------------------------------------------------------
    logic [1:0]    cond_q;     // condition of last cycle
    logic [CW-1:0] run_q;      // cycles the condition has held
    ubs_link_e     link_q;
    logic          resume_q;
    logic          bus_evt_q;

    // run length restarts on any change of condition
    wire cond_same = (line_cond == cond_q);
    // ceiling of the run counter
    wire run_max   = (run_q == CW'(IDLE_CYCLES + 1));
    // strictly more than the limit, hence the plus one
    wire se0_long  = line_se0 & cond_same &
                     (run_q >= CW'(SE0_CYC + 1));        // R16
    wire idle_long = line_j & cond_same &
                     (run_q >= CW'(IDLE_CYCLES + 1));    // R15

    // run length counter saturates so it never wraps
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cond_q <= 2'b00;
            run_q  <= '0;
        end else begin
            cond_q <= line_cond;
            if (!cond_same || !live) begin
                run_q <= '0;
            end else if (!run_max) begin
                run_q <= run_q + CW'(1);
            end
        end
    end

    // next link state
    ubs_link_e link_d;
    // bus reset wins when both limits are passed
    always_comb begin
        link_d = link_q;
        case (link_q)
            LS_ACTIVE: begin
                if (se0_long) begin
                    link_d = LS_RESET;
                end else if (idle_long) begin
                    link_d = LS_SUSPEND;
                end
            end
            LS_SUSPEND: begin
                // any non-idle line wakes the link
                if (!line_j) begin
                    link_d = LS_ACTIVE;
                end
            end
            LS_RESET: begin
                // reset ends when se0 goes away
                if (!line_se0) begin
                    link_d = LS_ACTIVE;
                end
            end
            default: link_d = LS_ACTIVE;
        endcase
        if (!live) begin
            link_d = LS_ACTIVE;
        end
    end

    // suspend edges feed the resume mark and the event pulse
    wire enter_susp = (link_d == LS_SUSPEND) & (link_q != LS_SUSPEND);
    wire leave_susp = (link_q == LS_SUSPEND) & (link_d != LS_SUSPEND) & live;

    // link state, resume mark and bus event pulse
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            link_q    <= LS_ACTIVE;
            resume_q  <= 1'b0;
            bus_evt_q <= 1'b0;
        end else begin
            link_q <= link_d;
            // resume stays until the next suspend or disable
            if (leave_susp) begin
                resume_q <= 1'b1;                          // R14
            end else if (enter_susp || !live) begin
                resume_q <= 1'b0;
            end
            bus_evt_q <= enter_susp | leave_susp;          // R18
        end
    end
    assign bus_event_flag = bus_evt_q;

    // ------------------------------------------------------------
    // response timeout
    // ------------------------------------------------------------
    localparam int TW = $clog2(TIMEOUT_CYC + 2);
    logic [TW-1:0] to_cnt_q;
    logic          timeout_q;
    // count full: the next idle waiting cycle sets the flag
    wire to_hit = (to_cnt_q == TW'(TIMEOUT_CYC));

    // counts idle line while a reply is awaited
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            to_cnt_q  <= '0;
            timeout_q <= 1'b0;
        end else if (!live) begin
            to_cnt_q  <= '0;
            timeout_q <= 1'b0;
        end else if (resp_wait && line_j) begin
            if (!to_hit) begin
                to_cnt_q <= to_cnt_q + TW'(1);
            end else begin
                timeout_q <= 1'b1;                         // R13
            end
        end else if (resp_wait) begin
            // line activity restarts the wait window
            to_cnt_q <= '0;
        end else if (!resp_wait && txn.valid) begin
            // a finished transaction clears old timeout
            to_cnt_q  <= '0;
            timeout_q <= 1'b0;
        end else begin
            to_cnt_q <= '0;
        end
    end

    // ------------------------------------------------------------
    // read view of both registers
    // ------------------------------------------------------------
    // bits 1 and 0 are live levels, bits 3 and 2 hold until cleared by logic or by a software write that clears bit 7, 4 or 9
    wire [3:0] status_bits = {timeout_q,                  // R13
                              resume_q,                   // R14
                              link_q == LS_SUSPEND,       // R15
                              link_q == LS_RESET};        // R16

    // reserved bit 6 reads back its reset one
    wire [31:0] attr_view = {21'h00_0000, ctrl_q[10:7], ctrl_q[BIT_RSVD6],
                             ctrl_q[5:4], status_bits};    // R17
    wire [31:0] eps_view  = {15'h0000,
                             ep_code_q[2],                // R4
                             ep_code_q[1],                // R4
                             ep_code_q[0],                // R4
                             overrun_q, 7'h00};

    // unmapped addresses read zero
    wire [31:0] rd_mux = hit_attr ? attr_view :
                         hit_eps  ? eps_view  : 32'h0000_0000;

    // fixed one wait state: answer on the second edge
    // readdata is loaded once per read, then held
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ack_q        <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            ack_q <= req & ~ack_q;
            if (avs_read && !ack_q) begin
                avs_readdata <= rd_mux;
            end
        end
    end

    // held high until the answering cycle
    // combinational, so a new request is held off at once
    assign avs_waitrequest = req & ~ack_q;

endmodule : ubs_core
`default_nettype wire

// [ubs_core_chk.sv]
// port assertions for ubs_core
// assumes one clk_sys domain and resetn active low
`default_nettype none
module ubs_core_chk
    import ubs_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        resetn,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire ubs_txn_s    txn,
    input wire logic        ctrl_enable,
    input wire logic        cpu_buffer_width_sel,
    input wire logic        xcvr_power_on_n,
    input wire logic        dplus_pullup_on,
    input wire logic        xcvr_function_on,
    input wire logic        remote_wake_drive,
    input wire logic        dplus_line_o,
    input wire logic        dplus_line_oe,
    input wire logic        dminus_line_o,
    input wire logic        dminus_line_oe,
    input wire logic        transaction_event_flag
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // accepted attribute writes per lane, and finished reads
    wire wr_a  = avs_write && !avs_waitrequest && avs_address == OFS_ATTR;
    wire wr_l0 = wr_a && avs_byteenable[0];
    wire wr_l1 = wr_a && avs_byteenable[1];
    wire rd_ok = avs_read && !avs_waitrequest;
    // a held-off request is always answered after one wait state
    one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("no answer after one wait state");
    wake_k_a: assert property (dplus_line_oe == remote_wake_drive && dminus_line_oe == remote_wake_drive
        && (!remote_wake_drive || (!dplus_line_o && dminus_line_o))) else $error("k state drive wrong");
    width_sel_a: assert property (wr_l1 |=> cpu_buffer_width_sel == $past(avs_writedata[10]))
        else $error("buffer width select not written");
    power_on_a: assert property (wr_l1 |=> xcvr_power_on_n == $past(avs_writedata[9]))
        else $error("power control not written");
    pullup_on_a: assert property (wr_l1 |=> dplus_pullup_on == $past(avs_writedata[8]))
        else $error("pull-up control not written");
    ctrl_en_a: assert property (wr_l0 |=> ctrl_enable == $past(avs_writedata[7]))
        else $error("controller enable not written");
    xcvr_wake_a: assert property (wr_l0 |=> xcvr_function_on == $past(avs_writedata[4])
        && remote_wake_drive == $past(avs_writedata[5])) else $error("lane0 controls not written");
    attr_read_a: assert property (rd_ok && avs_address == OFS_ATTR |-> avs_readdata[31:11] == 21'h0
        && avs_readdata[6] && avs_readdata[10] == cpu_buffer_width_sel) else $error("attribute read wrong");
    eps_read_a: assert property (rd_ok && avs_address == OFS_EP_STATUS |-> avs_readdata[31:17] == 15'h0
        && avs_readdata[6:0] == 7'h00) else $error("endpoint status reserved bits set");
    unmapped_a: assert property (rd_ok && avs_address != OFS_ATTR && avs_address != OFS_EP_STATUS
        |-> avs_readdata == 32'h0000_0000) else $error("unmapped read not zero");
    txn_flag_a: assert property (txn.valid && ctrl_enable && txn.ep != 2'h3 |=> transaction_event_flag)
        else $error("transaction event missing");
endmodule : ubs_core_chk
bind ubs_core ubs_core_chk u_chk (.*);
`default_nettype wire

// [ubs_host_model.sv]
// usb host seen from the device pins
// assumes host pull-downs on both lines, device pull-up on d+
`default_nettype none
module ubs_host_model (
    input wire logic       clk_sys,
    input wire logic [1:0] mode,            // 0 idle j, 1 se0, 2 traffic, 3 released
    input wire logic       dplus_pullup_on,
    input wire logic       dplus_line_o,
    input wire logic       dplus_line_oe,
    input wire logic       dminus_line_o,
    input wire logic       dminus_line_oe,
    output logic           dp_w,
    output logic           dm_w
);
    logic tog_q = 1'b0;    // traffic alternates k and j every cycle
    always_ff @(posedge clk_sys) begin
        tog_q <= ~tog_q;
    end
    // released lines fall to the resistor levels; a device drive wins
    wire hp = mode == 2'h0 ? 1'b1 : mode == 2'h2 ? tog_q : mode == 2'h3 ? dplus_pullup_on : 1'b0;
    wire hm = mode == 2'h2 ? ~tog_q : 1'b0;
    assign dp_w = dplus_line_oe ? dplus_line_o : hp;
    assign dm_w = dminus_line_oe ? dminus_line_o : hm;
endmodule : ubs_host_model
`default_nettype wire

// [tb_top.sv]
// self-checking bench for ubs_core with a host model on the lines
// assumes 40 MHz clk_sys and a shortened suspend count
`default_nettype none
module tb_top
    import ubs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int IDLE_T = 200;           // short suspend count, above se0 count
    logic        clk_sys = 1'b0;
    logic        resetn = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0]  avs_byteenable = 4'h0;
    logic [31:0] avs_readdata, rd;
    logic        avs_waitrequest;
    ubs_txn_s    txn = '0;
    logic [29:0] max_payload_setting = {10'h014, 10'h010, 10'h008};  // ep2 20, ep1 16, ep0 8
    logic        resp_wait = 1'b0;
    logic [1:0]  line_mode = 2'h0;
    wire logic   dplus_line_i, dminus_line_i;
    logic        dplus_line_o, dplus_line_oe, dminus_line_o, dminus_line_oe;
    logic        cpu_buffer_width_sel, xcvr_power_on_n, dplus_pullup_on, ctrl_enable;
    logic        xcvr_function_on, remote_wake_drive, bus_event_flag, transaction_event_flag;
    logic [2:0]  ep_code [3] = '{3'h0, 3'h0, 3'h0};   // expected codes
    logic        ovr = 1'b0;                           // expected overrun
    int          fail_count = 0, n_tests = 0, cycles = 0, bev_n = 0;
    ubs_core #(.IDLE_CYCLES(IDLE_T)) DUT (.*);
    ubs_host_model u_host (.clk_sys, .mode(line_mode), .dplus_pullup_on, .dplus_line_o, .dplus_line_oe,
        .dminus_line_o, .dminus_line_oe, .dp_w(dplus_line_i), .dm_w(dminus_line_i));
    always #12.5 clk_sys = ~clk_sys;
    // watchdog and bus event pulse count
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (bus_event_flag === 1'b1) bev_n <= bev_n + 1;
        if (cycles == 20000) begin
            fail_count++;
            conclude();
        end
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk_sys);
        {avs_write, avs_read, avs_address, avs_writedata, avs_byteenable} <= {wr, ~wr, a, d, be};
        // the loop assumes no cycle count, the count is then checked against 2; only the watchdog ends a hung wait
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        check("wait cycles", n, 2);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    // one transaction report, then the status register is compared
    task automatic send(input logic [1:0] ep, input logic [2:0] code, input logic [9:0] b, input logic take);
        @(posedge clk_sys);
        txn <= '{1'b1, ep, code, b};
        @(posedge clk_sys);
        txn.valid <= 1'b0;
        if (take) begin
            ep_code[ep] = code;
            ovr = ((code == CODE_OUT_D0 || code == CODE_OUT_D1) && b > max_payload_setting[ep*10 +: 10])
                || (code == CODE_SETUP && b > 10'h008);
        end
        #1 check("event flag", 32'(transaction_event_flag), 32'(take));
        bus(1'b0, OFS_EP_STATUS, 32'h0000_0000, 4'h0);
        check("ep status", rd, {15'h0, ep_code[2], ep_code[1], ep_code[0], ovr, 7'h00});
    endtask : send
    task automatic t_reset();
        bus(1'b0, OFS_ATTR, 32'h0000_0000, 4'h0);
        check("attr reset", rd, ATTR_RESET);
        check("outputs reset", 32'({cpu_buffer_width_sel, xcvr_power_on_n, ctrl_enable, dplus_line_oe}), 0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_attr();
        bus(1'b1, OFS_ATTR, 32'hFFFF_FFFF, 4'hF);
        bus(1'b0, OFS_ATTR, 32'h0000_0000, 4'h0);
        check("attr all ones", rd, 32'h0000_07F0);
        check("controls", 32'({cpu_buffer_width_sel, xcvr_power_on_n, dplus_pullup_on, ctrl_enable,
            xcvr_function_on}), 32'h0000_001F);
        check("k state", 32'({dplus_line_i, dminus_line_i}), 32'h0000_0001);
        bus(1'b1, OFS_ATTR, 32'h0000_0000, 4'h1);
        bus(1'b0, OFS_ATTR, 32'h0000_0000, 4'h0);
        check("lane0 cleared", rd, 32'h0000_0740);
        check("k released", 32'(dplus_line_i), 32'h0000_0001);
        bus(1'b1, 8'h14, 32'hFFFF_FFFF, 4'hF);
        bus(1'b0, 8'h14, 32'h0000_0000, 4'h0);
        check("unmapped", rd, 32'h0000_0000);
        $display("test attribute done");
    endtask : t_attr
    task automatic t_codes();
        logic [2:0] cd [6];
        cd = '{CODE_IN_ACK, CODE_IN_NAK, CODE_OUT_D0, CODE_OUT_D1, CODE_SETUP, CODE_ISO_END};
        line_mode <= 2'h2;
        send(2'h0, CODE_IN_NAK, 10'h000, 1'b0);
        bus(1'b1, OFS_ATTR, 32'h0000_0390, 4'h3);
        for (int i = 0; i < 6; i++) send(2'(i % 3), cd[i], 10'h008, 1'b1);
        send(2'h1, CODE_OUT_D1, 10'h011, 1'b1);
        send(2'h2, CODE_OUT_D0, 10'h014, 1'b1);
        send(2'h0, CODE_SETUP, 10'h009, 1'b1);
        bus(1'b1, OFS_EP_STATUS, 32'hFFFF_FFFF, 4'hF);
        send(2'h3, CODE_IN_ACK, 10'h000, 1'b0);
        $display("test codes done");
    endtask : t_codes
    task automatic line_read(input int n, input logic [3:0] exp);
        repeat (n) @(posedge clk_sys);
        bus(1'b0, OFS_ATTR, 32'h0000_0000, 4'h0);
        check("line status", 32'(rd[3:0]), 32'(exp));
    endtask : line_read
    task automatic t_line();
        line_mode <= 2'h1;
        line_read(80, 4'h0);
        line_read(60, 4'h1);
        line_mode <= 2'h3;     // idle j held by the pull-up alone
        line_read(260, 4'h2);
        line_mode <= 2'h2;
        line_read(10, 4'h4);
        check("bus events", bev_n, 2);
        line_mode <= 2'h0;
        resp_wait <= 1'b1;
        line_read(70, 4'hC);
        resp_wait <= 1'b0;
        line_mode <= 2'h2;
        send(2'h0, CODE_IN_ACK, 10'h000, 1'b1);
        line_read(1, 4'h4);
        $display("test line done");
    endtask : t_line
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude
    initial begin
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        t_reset();
        t_attr();
        t_codes();
        t_line();
        conclude();
    end
endmodule : tb_top
`default_nettype wire
